// [verilog/sfe_cmd.sv]
`timescale 1ns/1ps
`include "sfe_params.svh"

// Notes on behaviour
// - 77h, 24 dummy bits, wrap byte stored
// - Quad reads stay inside selected section
// - Length field picks 8/16/32/64; default off
// - Sections align in 256-byte pages; single-line
// - 81h plus address erases containing page
// - Erase needs write enable latch set first
// - Address erases end exactly after 32 bits
// - 60h/C7h chip erase ends after eight bits
// - Timed erase cycle starts at select rise
// - Busy bit high while erasing, then low
// - Latch cleared before erase cycle ends
// - 20h plus address erases containing sector
// - 52h plus address erases containing half block
// - D8h plus address erases containing block
// - Protected regions are never erased
// - Chip erase only with all protect bits zero
// - Wrapped reads return to section start
module sfe_cmd
  import sfe_pkg::*;
#(
  parameter int unsigned PAGE_ERASE_CYC   = `SFE_PAGE_ERASE_US * `SFE_CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYC = `SFE_SECTOR_ERASE_US * `SFE_CLK_MHZ,
  parameter int unsigned HALF_ERASE_CYC   = `SFE_HALF_ERASE_US * `SFE_CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYC  = `SFE_BLOCK_ERASE_US * `SFE_CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYC   = `SFE_CHIP_ERASE_US * `SFE_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Serial pins from the host.
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        si_i,
  // Protection settings from the status register.
  input  wire logic [4:0]  protect_bits_i,
  // Read address port from the quad read path.
  input  wire logic        rd_load_i,
  input  wire logic [23:0] rd_addr_i,
  input  wire logic        rd_step_i,
  // Status and results.
  output logic             write_in_progress_o,
  output logic             write_enable_latch_o,
  output sfe_wrap_s        wrap_o,
  output logic             erase_start_o,
  output sfe_erase_s       erase_o,
  output logic      [23:0] rd_addr_o
);
  // -------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // -------------------------------------------------------------------------
  logic rst_meta_reg, rst_n;
  logic cs_meta_reg, cs_sync_reg, cs_d_reg;
  logic sclk_meta_reg, sclk_sync_reg, sclk_d_reg;
  logic si_meta_reg, si_sync_reg;
  // Reset enters asynchronously but is released on the clock.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end
  // The link clock is only sampled; its edges are found from the synced copy.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
      cs_d_reg      <= 1'b1;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_d_reg    <= 1'b0;
      si_meta_reg   <= 1'b0;
      si_sync_reg   <= 1'b0;
    end else begin
      cs_meta_reg   <= cs_n_i;
      cs_sync_reg   <= cs_meta_reg;
      cs_d_reg      <= cs_sync_reg;
      sclk_meta_reg <= sclk_i;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_d_reg    <= sclk_sync_reg;
      si_meta_reg   <= si_i;
      si_sync_reg   <= si_meta_reg;
    end
  end
  logic cs_rise, cs_fall, sclk_rise;
  assign cs_rise   = cs_sync_reg & ~cs_d_reg;
  assign cs_fall   = ~cs_sync_reg & cs_d_reg;
  assign sclk_rise = sclk_sync_reg & ~sclk_d_reg;
  // -------------------------------------------------------------------------
  // Frame shifter: single-line input, sampled on the serial clock rise
  // -------------------------------------------------------------------------
  logic [5:0]  cnt_reg, cnt_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [23:0] addr_reg, addr_next;
  // The counter saturates so a long frame never aliases onto a valid length.
  always_comb begin
    cnt_next  = cnt_reg;
    cmd_next  = cmd_reg;
    addr_next = addr_reg;
    if (cs_fall) begin
      cnt_next = 6'h00;
    end else if (!cs_sync_reg && sclk_rise) begin
      if (cnt_reg != `SFE_BITS_SAT) begin
        cnt_next = cnt_reg + 6'h01;
      end
      if (cnt_reg < `SFE_BITS_CMD) begin
        cmd_next = {cmd_reg[6:0], si_sync_reg};
      end else begin
        addr_next = {addr_reg[22:0], si_sync_reg};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 6'h00;
      cmd_reg  <= 8'h00;
      addr_reg <= 24'h000000;
    end else begin
      cnt_reg  <= cnt_next;
      cmd_reg  <= cmd_next;
      addr_reg <= addr_next;
    end
  end
  // -------------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------------
  function automatic sfe_kind_e kind_of(input logic [7:0] cmd);
    case (cmd)
      `SFE_CMD_PAGE_ERASE:   kind_of = EK_PAGE;
      `SFE_CMD_SECTOR_ERASE: kind_of = EK_SECTOR;
      `SFE_CMD_HALF_ERASE:   kind_of = EK_HALF;
      `SFE_CMD_BLOCK_ERASE:  kind_of = EK_BLOCK;
      default:               kind_of = EK_CHIP;
    endcase
  endfunction : kind_of
  function automatic logic [24:0] size_of(input sfe_kind_e kind);
    case (kind)
      EK_PAGE:   size_of = `SFE_SIZE_PAGE;
      EK_SECTOR: size_of = `SFE_SIZE_SECTOR;
      EK_HALF:   size_of = `SFE_SIZE_HALF;
      EK_BLOCK:  size_of = `SFE_SIZE_BLOCK;
      default:   size_of = `SFE_SIZE_ARRAY;
    endcase
  endfunction : size_of
  // Protected span: bits 2..0 set its size, bit 3 puts it at the bottom, bit 4 uses sectors.
  function automatic logic prot_hit(input sfe_kind_e kind, input logic [23:0] a,
                                    input logic [4:0] bp);
    logic [24:0] rsz, rlo, psz, plo;
    rsz = size_of(kind);
    rlo = {1'b0, a} & ~(rsz - 25'h0000001);
    psz = (bp[4] ? `SFE_SIZE_SECTOR : `SFE_SIZE_BLOCK) << (bp[2:0] - 3'h1);
    plo = bp[3] ? 25'h0000000 : (`SFE_SIZE_ARRAY - psz);
    if (bp[2:0] == 3'h0) begin
      prot_hit = 1'b0;
    end else begin
      prot_hit = (rlo < plo + psz) && (plo < rlo + rsz);
    end
  endfunction : prot_hit
  function automatic logic [31:0] cycles_of(input sfe_kind_e kind);
    case (kind)
      EK_PAGE:   cycles_of = PAGE_ERASE_CYC;
      EK_SECTOR: cycles_of = SECTOR_ERASE_CYC;
      EK_HALF:   cycles_of = HALF_ERASE_CYC;
      EK_BLOCK:  cycles_of = BLOCK_ERASE_CYC;
      default:   cycles_of = CHIP_ERASE_CYC;
    endcase
  endfunction : cycles_of
  // -------------------------------------------------------------------------
  // Command decision at the chip-select rise
  // -------------------------------------------------------------------------
  logic      addr_cmd, addr_ok, chip_ok, prot_now, start_req, wren_ok, wrap_ok;
  sfe_kind_e kind_now;
  // Frames are judged by exact bit count, so an early or late rise rejects.
  always_comb begin
    addr_cmd  = (cmd_reg == `SFE_CMD_PAGE_ERASE) || (cmd_reg == `SFE_CMD_SECTOR_ERASE) ||
                (cmd_reg == `SFE_CMD_HALF_ERASE) || (cmd_reg == `SFE_CMD_BLOCK_ERASE);
    addr_ok   = addr_cmd && (cnt_reg == `SFE_BITS_ADDR);
    chip_ok   = ((cmd_reg == `SFE_CMD_CHIP_ERASE_A) || (cmd_reg == `SFE_CMD_CHIP_ERASE_B)) &&
                (cnt_reg == `SFE_BITS_CMD);
    kind_now  = chip_ok ? EK_CHIP : kind_of(cmd_reg);
    prot_now  = prot_hit(kind_now, addr_reg, protect_bits_i);
    start_req = cs_rise && write_enable_latch_o &&
                ((addr_ok && !prot_now) ||
                 (chip_ok && (protect_bits_i == 5'h00)));
    wren_ok   = cs_rise && (cmd_reg == `SFE_CMD_WRITE_ENABLE) && (cnt_reg == `SFE_BITS_CMD);
    wrap_ok   = cs_rise && (cmd_reg == `SFE_CMD_WRAP_SETUP) && (cnt_reg == `SFE_BITS_WRAP);
  end
  // -------------------------------------------------------------------------
  // Control state, latch, wrap settings and erase timer
  // -------------------------------------------------------------------------
  sfe_state_e  state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic        wel_next, wip_next, start_next;
  sfe_wrap_s   wrap_next;
  sfe_erase_s  erase_next;
  // While erasing every frame is dropped; status stays visible on the port.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    wel_next   = write_enable_latch_o;
    wip_next   = write_in_progress_o;
    wrap_next  = wrap_o;
    erase_next = erase_o;
    start_next = 1'b0;
    case (state_reg)
      ST_READY: begin
        if (start_req) begin
          state_next = ST_ERASING;
          timer_next = cycles_of(kind_now);
          wip_next   = 1'b1;
          wel_next   = 1'b0;
          start_next = 1'b1;
          erase_next = '{kind: kind_now, addr: chip_ok ? 24'h000000 : addr_reg};
        end else if (wren_ok) begin
          wel_next = 1'b1;
        end else if (wrap_ok) begin
          wrap_next = sfe_wrap_s'(addr_reg[`SFE_WRAP_MSB:`SFE_WRAP_LSB]);
        end
      end
      ST_ERASING: begin
        if (timer_reg <= 32'h00000001) begin
          state_next = ST_READY;
          wip_next   = 1'b0;
        end else begin
          timer_next = timer_reg - 32'h00000001;
        end
      end
      default: begin
        state_next = ST_READY;
        wip_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg            <= ST_READY;
      timer_reg            <= 32'h00000000;
      write_enable_latch_o <= 1'b0;
      write_in_progress_o  <= 1'b0;
      wrap_o               <= sfe_wrap_s'(`SFE_WRAP_RESET);
      erase_start_o        <= 1'b0;
      erase_o              <= '{kind: EK_PAGE, addr: 24'h000000};
    end else begin
      state_reg            <= state_next;
      timer_reg            <= timer_next;
      write_enable_latch_o <= wel_next;
      write_in_progress_o  <= wip_next;
      wrap_o               <= wrap_next;
      erase_start_o        <= start_next;
      erase_o              <= erase_next;
    end
  end
  // -------------------------------------------------------------------------
  // Read address for the quad read path
  // -------------------------------------------------------------------------
  logic [23:0] rd_addr_next, rd_wrap_addr;
  sfe_wrap_addr u_wrap (
    .addr_i (rd_addr_o),
    .wrap_i (wrap_o),
    .next_o (rd_wrap_addr)
  );
  // A load takes priority so a new command never inherits a stale step.
  always_comb begin
    rd_addr_next = rd_addr_o;
    if (rd_load_i) begin
      rd_addr_next = rd_addr_i;
    end else if (rd_step_i) begin
      rd_addr_next = rd_wrap_addr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_addr_o <= 24'h000000;
    end else begin
      rd_addr_o <= rd_addr_next;
    end
  end
  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  AST_WEL_BEFORE_ERASE: assert property (erase_start_o |-> $past(write_enable_latch_o))
    else $error("Erase started without write enable latch.");
  AST_ADDR_FRAME_LEN: assert property (
    erase_start_o && (erase_o.kind != EK_CHIP) |-> $past(cnt_reg) == 6'h20)
    else $error("Address erase started with wrong frame length.");
  AST_CHIP_FRAME: assert property (
    erase_start_o && (erase_o.kind == EK_CHIP) |->
      ($past(cnt_reg) == 6'h08) && ($past(protect_bits_i) == 5'h00))
    else $error("Chip erase started with wrong length or protection.");
  AST_START_AT_RISE: assert property (
    erase_start_o |-> $past(cs_rise) && write_in_progress_o && !$past(write_in_progress_o))
    else $error("Erase start not tied to select rise and busy set.");
  AST_BUSY_ENDS: assert property (
    $fell(write_in_progress_o) |-> $past(timer_reg) <= 32'h00000001)
    else $error("Busy dropped before erase timer expired.");
  AST_BUSY_HOLDS: assert property (
    write_in_progress_o && (timer_reg > 32'h00000001) |=> write_in_progress_o)
    else $error("Busy dropped while timer still running.");
  AST_WEL_CLEARED: assert property (erase_start_o |-> !write_enable_latch_o)
    else $error("Write enable latch still set after erase start.");
  AST_NO_PROTECTED: assert property (
    erase_start_o && (erase_o.kind != EK_CHIP) |-> !$past(prot_now))
    else $error("Erase started on protected region.");
  AST_PAGE_KIND: assert property (
    erase_start_o && ($past(cmd_reg) == 8'h81) |-> erase_o.kind == EK_PAGE)
    else $error("Page erase decoded as another kind.");
  AST_IGNORE_BUSY: assert property (
    write_in_progress_o && (timer_reg > 32'h00000001) |=> !erase_start_o && $stable(wrap_o))
    else $error("Command accepted while erase running.");
  AST_WRAP_STORE: assert property (
    wrap_ok && (state_reg == ST_READY) && !start_req |=> wrap_o == $past(addr_reg[6:4]))
    else $error("Wrap byte not stored.");
  AST_WRAP_SECTION: assert property (
    rd_step_i && !rd_load_i && !wrap_o.wrap_disable_bit |=>
      rd_addr_o[23:6] == $past(rd_addr_o[23:6]))
    else $error("Wrapped read left its section.");
  CVR_CHIP_ERASE: cover property (erase_start_o && (erase_o.kind == EK_CHIP));
  CVR_PAGE_ERASE: cover property (erase_start_o && (erase_o.kind == EK_PAGE));
  CVR_ERASE_DONE: cover property ($fell(write_in_progress_o));
  CVR_WRAP_ON:    cover property (wrap_ok ##1 !wrap_o.wrap_disable_bit);

endmodule : sfe_cmd

// [verilog/sfe_params.svh]
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// ---------------------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------------------
`define SFE_CMD_WRITE_ENABLE   8'h06
`define SFE_CMD_WRAP_SETUP     8'h77
`define SFE_CMD_PAGE_ERASE     8'h81
`define SFE_CMD_SECTOR_ERASE   8'h20
`define SFE_CMD_HALF_ERASE     8'h52
`define SFE_CMD_BLOCK_ERASE    8'hD8
`define SFE_CMD_CHIP_ERASE_A   8'h60
`define SFE_CMD_CHIP_ERASE_B   8'hC7

// ---------------------------------------------------------------------------
// Frame lengths in serial bits
// ---------------------------------------------------------------------------
`define SFE_BITS_CMD           6'h08
`define SFE_BITS_ADDR          6'h20
`define SFE_BITS_WRAP          6'h28
`define SFE_BITS_SAT           6'h3F

// ---------------------------------------------------------------------------
// Region sizes in bytes, 25 bits wide to hold the whole 24-bit space
// ---------------------------------------------------------------------------
`define SFE_SIZE_PAGE          25'h0000100
`define SFE_SIZE_SECTOR        25'h0001000
`define SFE_SIZE_HALF          25'h0008000
`define SFE_SIZE_BLOCK         25'h0010000
`define SFE_SIZE_ARRAY         25'h1000000

// ---------------------------------------------------------------------------
// Wrap settings: reset value and position of the wrap byte in the shift word
// ---------------------------------------------------------------------------
`define SFE_WRAP_RESET         3'h1
`define SFE_WRAP_MSB           6
`define SFE_WRAP_LSB           4

// ---------------------------------------------------------------------------
// Timing: clock rate and erase times in microseconds
// ---------------------------------------------------------------------------
`define SFE_CLK_MHZ            10
`define SFE_PAGE_ERASE_US      1000
`define SFE_SECTOR_ERASE_US    2000
`define SFE_HALF_ERASE_US      4000
`define SFE_BLOCK_ERASE_US     8000
`define SFE_CHIP_ERASE_US      100000

`endif

// [verilog/sfe_pkg.sv]
package sfe_pkg;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    EK_PAGE   = 3'h0,
    EK_SECTOR = 3'h1,
    EK_HALF   = 3'h2,
    EK_BLOCK  = 3'h3,
    EK_CHIP   = 3'h4
  } sfe_kind_e;

  typedef enum logic [1:0] {
    ST_READY   = 2'b01,
    ST_ERASING = 2'b10
  } sfe_state_e;

  // Wrap settings in the order of the wrap byte: length field above disable bit.
  typedef struct packed {
    logic [1:0] wrap_length_field;
    logic       wrap_disable_bit;
  } sfe_wrap_s;

  typedef struct packed {
    sfe_kind_e   kind;
    logic [23:0] addr;
  } sfe_erase_s;

endpackage : sfe_pkg

// [verilog/sfe_wrap_addr.sv]
`timescale 1ns/1ps

module sfe_wrap_addr
  import sfe_pkg::*;
(
  // Current read address and settings.
  input  wire logic [23:0] addr_i,
  input  wire sfe_wrap_s   wrap_i,
  // Address of the following byte.
  output logic      [23:0] next_o
);

  // -------------------------------------------------------------------------
  // Section arithmetic
  // -------------------------------------------------------------------------
  logic [23:0] mask;
  logic [23:0] incr;

  // Sections are 8, 16, 32 or 64 bytes and aligned, so they never leave a page.
  always_comb begin
    mask = {18'h00000, 6'h07};
    case (wrap_i.wrap_length_field)
      2'h0:    mask = {18'h00000, 6'h07};
      2'h1:    mask = {18'h00000, 6'h0F};
      2'h2:    mask = {18'h00000, 6'h1F};
      default: mask = {18'h00000, 6'h3F};
    endcase
    incr = addr_i + 24'h000001;
    if (wrap_i.wrap_disable_bit) begin
      next_o = incr;
    end else begin
      next_o = (addr_i & ~mask) | (incr & mask);
    end
  end

endmodule : sfe_wrap_addr

// [verif/sfe_host_model.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Serial host model
// ---------------------------------------------------------------------------
module sfe_host_model (
  // System clock that paces the host.
  input  wire logic clk_i,
  // Serial pins towards the device.
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  // Half of the 800 ns serial period, counted in system clocks.
  localparam int HALF = 4;

  // Idle pins: select high, serial clock parked low in mode 0.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o   = 1'b1;
  end

  // Sends the n low bits of b MSB first; the serial clock stands still between frames.
  // After the frame the data line is driven to the inverse of its last bit as select rises.
  task automatic frame(input logic [39:0] b, input int n);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o <= b[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o;
    repeat (2 * HALF) @(posedge clk_i);
  endtask : frame
endmodule : sfe_host_model

// [verif/sfe_cmd_tb_top.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// Testbench top
// ---------------------------------------------------------------------------
module sfe_cmd_tb_top;
  import sfe_pkg::*;
  // Shortened busy lengths; page is long enough to overlap two later frames.
  localparam int CYC [5] = '{600, 200, 250, 300, 350};
  localparam int LIMIT   = 40000;

  logic        clk_i;
  logic        arst_n_i;
  logic        cs_n_i;
  logic        sclk_i;
  logic        si_i;
  logic [4:0]  protect_bits_i;
  logic        rd_load_i;
  logic [23:0] rd_addr_i;
  logic        rd_step_i;
  logic        write_in_progress_o;
  logic        write_enable_latch_o;
  sfe_wrap_s   wrap_o;
  logic        erase_start_o;
  sfe_erase_s  erase_o;
  logic [23:0] rd_addr_o;
  int          n_errors;
  int          cmp_count;
  int          n_starts;
  int          busy_cnt;
  int          cyc_cnt;
  sfe_erase_s  last_erase;

  sfe_cmd #(
    .PAGE_ERASE_CYC  (CYC[0]),
    .SECTOR_ERASE_CYC(CYC[1]),
    .HALF_ERASE_CYC  (CYC[2]),
    .BLOCK_ERASE_CYC (CYC[3]),
    .CHIP_ERASE_CYC  (CYC[4])
  ) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .si_i(si_i),
    .protect_bits_i(protect_bits_i), .rd_load_i(rd_load_i), .rd_addr_i(rd_addr_i),
    .rd_step_i(rd_step_i), .write_in_progress_o(write_in_progress_o),
    .write_enable_latch_o(write_enable_latch_o), .wrap_o(wrap_o),
    .erase_start_o(erase_start_o), .erase_o(erase_o), .rd_addr_o(rd_addr_o));

  sfe_host_model host (.clk_i(clk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i));

  // Clock generator, 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Monitor: counts start pulses, busy cycles and the run length; values before the edge.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (erase_start_o === 1'b1) begin
      n_starts++;
      last_erase = erase_o;
    end
    if (write_in_progress_o === 1'b1) busy_cnt++;
    if (cyc_cnt == LIMIT) begin
      n_errors++;
      $display("MISMATCH at %0t: run did not finish, seen %h expected %h", $time, cyc_cnt, 0);
      close_out();
    end
  end

  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Bounded wait for the busy flag to drop.
  task automatic wait_idle();
    int i;
    i = 0;
    while (write_in_progress_o !== 1'b0 && i < 2000) begin
      @(posedge clk_i);
      #1;
      i++;
    end
  endtask : wait_idle

  task automatic wren();
    host.frame(40'h06, 8);
  endtask : wren

  // One erase frame; judges acceptance, the reported job, latch, busy flag and busy length.
  task automatic erase_try(input logic [39:0] b, input int n, input bit ok,
                           input sfe_erase_s e);
    int s0;
    s0 = n_starts;
    busy_cnt = 0;
    host.frame(b, n);
    #1;
    chk(n_starts - s0, {31'h0, ok});
    if (ok) begin
      chk(last_erase, e);
      chk(write_enable_latch_o, 1'b0);
      chk(write_in_progress_o, 1'b1);
      wait_idle();
      chk(busy_cnt, CYC[e.kind]);
      chk(write_in_progress_o, 1'b0);
    end else begin
      chk(write_in_progress_o, 1'b0);
    end
  endtask : erase_try

  // Loads a read address, steps twice and compares the result.
  task automatic rd_walk(input logic [23:0] a, input logic [23:0] exp);
    @(posedge clk_i);
    rd_load_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge clk_i);
    rd_load_i <= 1'b0;
    rd_step_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    rd_step_i <= 1'b0;
    #1;
    chk(rd_addr_o, exp);
  endtask : rd_walk

  task automatic t_reset();
    chk({write_in_progress_o, write_enable_latch_o}, 2'h0);
    chk(wrap_o, 3'h1);
    chk(erase_o, 27'h0);
    chk(rd_addr_o, 24'h0);
    $display("Test reset done");
  endtask : t_reset

  task automatic t_latch();
    erase_try({8'h81, 24'h000100}, 32, 1'b0, '0);
    wren();
    chk(write_enable_latch_o, 1'b1);
    $display("Test latch done");
  endtask : t_latch

  task automatic t_kinds();
    logic [7:0] code [4] = '{8'h81, 8'h20, 8'h52, 8'hD8};
    for (int k = 0; k < 4; k++) begin
      wren();
      erase_try({8'h00, code[k], 24'hABCDEF}, 32, 1'b1,
                {sfe_kind_e'(k), 24'hABCDEF});
    end
    wren();
    erase_try(40'h60, 8, 1'b1, {EK_CHIP, 24'h0});
    wren();
    erase_try(40'hC7, 8, 1'b1, {EK_CHIP, 24'h0});
    $display("Test erase kinds done");
  endtask : t_kinds

  task automatic t_bad_len();
    wren();
    erase_try({8'h20, 24'h001000} >> 1, 31, 1'b0, '0);
    erase_try({7'h0, 8'h20, 24'h001000, 1'b0}, 33, 1'b0, '0);
    erase_try({8'h60, 1'b0}, 9, 1'b0, '0);
    chk(write_enable_latch_o, 1'b1);
    $display("Test frame length done");
  endtask : t_bad_len

  task automatic t_protect();
    @(posedge clk_i);
    protect_bits_i <= 5'h01;
    wren();
    erase_try({8'hD8, 24'hFF1234}, 32, 1'b0, '0);
    erase_try(40'hC7, 8, 1'b0, '0);
    erase_try({8'h20, 24'h7F0000}, 32, 1'b1, {EK_SECTOR, 24'h7F0000});
    @(posedge clk_i);
    protect_bits_i <= 5'h00;
    $display("Test protection done");
  endtask : t_protect

  task automatic t_busy();
    int s0;
    wren();
    s0 = n_starts;
    host.frame({8'h81, 24'h000200}, 32);
    wren();
    host.frame({8'h20, 24'h002000}, 32);
    #1;
    chk(n_starts - s0, 1);
    chk({write_in_progress_o, write_enable_latch_o}, 2'h2);
    wait_idle();
    $display("Test busy done");
  endtask : t_busy

  task automatic t_wrap();
    logic [23:0] m;
    for (int l = 0; l < 4; l++) begin
      host.frame({8'h77, 24'h0, 1'b0, 2'(l), 1'b0, 4'h0}, 40);
      chk(wrap_o, {2'(l), 1'b0});
      m = (24'h8 << l) - 24'h1;
      rd_walk(24'h1234FE, 24'h1234FE & ~m);
    end
    host.frame({8'h77, 24'h0, 8'h50}, 40);
    chk(wrap_o, 3'h5);
    rd_walk(24'h1234FE, 24'h123500);
    $display("Test wrap done");
  endtask : t_wrap

  // Main sequence.
  initial begin
    n_errors = 0;
    cmp_count = 0;
    n_starts = 0;
    busy_cnt = 0;
    cyc_cnt = 0;
    arst_n_i = 1'b0;
    protect_bits_i = 5'h00;
    rd_load_i = 1'b0;
    rd_addr_i = 24'h000000;
    rd_step_i = 1'b0;
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    t_reset();
    t_latch();
    t_kinds();
    t_bad_len();
    t_protect();
    t_busy();
    t_wrap();
    close_out();
  end
endmodule : sfe_cmd_tb_top
